// ==== shared/srx_pkg.sv ====
// Constants and carrier types for the serdes valid-mask and tx interrupt enable bank
package srx_pkg;

  // ************************************************
  // Register offsets
  // ************************************************
  localparam logic [7:0] SRX_ADDR_RXA_VALID = 8'h0A;
  localparam logic [7:0] SRX_ADDR_RXB_DATA  = 8'h0B;
  localparam logic [7:0] SRX_ADDR_RXB_VALID = 8'h0C;
  localparam logic [7:0] SRX_ADDR_TX_IRQ_EN = 8'h0D;

  // ************************************************
  // Reset values and field layout
  // ************************************************
  localparam logic [7:0] SRX_RST_BYTE   = 8'h00;
  localparam logic [3:0] SRX_RST_EN     = 4'h0;
  localparam logic [7:0] SRX_ALL_VALID  = 8'hFF;
  localparam int         SRX_EN_W       = 4;
  localparam int         SRX_BIT_UNDER  = 3;
  localparam int         SRX_BIT_OVER   = 2;
  localparam int         SRX_BIT_DONE   = 1;
  localparam int         SRX_BIT_EMPTY  = 0;

  // ************************************************
  // Carrier types
  // ************************************************
  // Host register access, already decoded from the serial host port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srx_reg_req_t;

  // One received byte from a channel receiver
  typedef struct packed {
    logic       load;
    logic [7:0] data;
    logic [7:0] valid;
  } srx_rx_t;

  // Transmit path events
  typedef struct packed {
    logic data_wr;
    logic sample_req;
    logic byte_end;
    logic stat_rd;
  } srx_tx_ev_t;

endpackage

// ==== rtl/srx_regs.sv ====
// Receive valid masks, channel B data and transmit interrupt enable bank
`timescale 1ns/10ps

// What this block does
// [R1] Channel A valid mask is a read-only byte, one bit per data bit.
// [R2] Channel A all-valid flag set means all eight data bits valid.
// [R3] Channel B byte is read-only, first received bit in bit 0.
// [R4] Channel B valid mask is a read-only byte, one bit per data bit.
// [R5] Channel B all-valid flag set means every data bit is valid.
// [R6] Host writes zeroes to enable bits 7:4; they are not stored.
// [R7] Enable bit 3 gates the transmit underflow interrupt.
// [R8] Underflow when the transmitter samples while no byte is held, once a first byte has moved into the shifter.
// [R9] Enable bit 2 gates the transmit overflow interrupt.
// [R10] Overflow when host writes before the held byte moved to shifter.
// [R11] Enable bit 1 gates the transmit done interrupt.
// [R12] Done when a byte ends and nothing more waits to send.
// [R13] Enable bit 0 gates the transmit empty interrupt.
// [R14] Empty when the held byte moves into the shifter.
// [R15] Status bits set and readable whatever the enables say.
// [R16] All-valid flag set on load only if every bit is valid.
// [R17] Interrupt request asserts while any enabled status bit is pending.
module srx_regs
  import srx_pkg::*;
(
  input  wire logic         CORE_CLK,
  input  wire logic         RST_B,
  input  wire srx_reg_req_t REG_REQ,
  output logic [7:0]        REG_RDATA,
  input  wire srx_rx_t      RXA,
  input  wire srx_rx_t      RXB,
  output logic              RXA_ALL_VALID,
  output logic              RXB_ALL_VALID,
  input  wire srx_tx_ev_t   TX,
  output logic [3:0]        TX_STATUS,
  output logic              TX_HOLD_FULL,
  output logic              TX_IRQ
);

  // ************************************************
  // Receive side state
  // ************************************************
  logic [7:0] rxa_mask_ff;
  logic [7:0] nxt_rxa_mask;
  logic [7:0] rxb_data_ff;
  logic [7:0] nxt_rxb_data;
  logic [7:0] rxb_mask_ff;
  logic [7:0] nxt_rxb_mask;
  logic       rxa_all_ff;
  logic       nxt_rxa_all;
  logic       rxb_all_ff;
  logic       nxt_rxb_all;

  // Capture the mask on each load strobe, and the byte too on a channel B load
  always_comb begin
    nxt_rxa_mask = rxa_mask_ff;
    nxt_rxa_all  = rxa_all_ff;
    nxt_rxb_data = rxb_data_ff;
    nxt_rxb_mask = rxb_mask_ff;
    nxt_rxb_all  = rxb_all_ff;
    if (RXA.load) begin
      nxt_rxa_mask = RXA.valid;                     // R1
      nxt_rxa_all  = (RXA.valid == SRX_ALL_VALID);  // R16
    end
    if (RXB.load) begin
      nxt_rxb_data = RXB.data;                      // R3
      nxt_rxb_mask = RXB.valid;                     // R4
      nxt_rxb_all  = (RXB.valid == SRX_ALL_VALID);  // R16
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rxa_mask_ff <= SRX_RST_BYTE;
      rxa_all_ff  <= 1'b0;
      rxb_data_ff <= SRX_RST_BYTE;
      rxb_mask_ff <= SRX_RST_BYTE;
      rxb_all_ff  <= 1'b0;
    end else begin
      rxa_mask_ff <= nxt_rxa_mask;
      rxa_all_ff  <= nxt_rxa_all;
      rxb_data_ff <= nxt_rxb_data;
      rxb_mask_ff <= nxt_rxb_mask;
      rxb_all_ff  <= nxt_rxb_all;
    end
  end

  // Flag and mask update in the same edge, so the host never sees them disagree
  assign RXA_ALL_VALID = rxa_all_ff;  // R2
  assign RXB_ALL_VALID = rxb_all_ff;  // R5

  // ************************************************
  // Transmit holding register tracking
  // ************************************************
  logic                hold_full_ff;
  logic                nxt_hold_full;
  logic                sent_any_ff;
  logic                nxt_sent_any;
  logic                load_now;
  logic [SRX_EN_W-1:0] tx_set;
  logic [SRX_EN_W-1:0] tx_clr;

  // The shifter takes the held byte when it asks for data and one is there
  assign load_now = TX.sample_req & hold_full_ff;

  // Event detection; underflow and done wait until a first byte went out
  always_comb begin
    nxt_hold_full = TX.data_wr | (hold_full_ff & ~load_now);
    nxt_sent_any  = sent_any_ff | load_now;
    tx_set        = '0;
    tx_set[SRX_BIT_UNDER] = TX.sample_req & ~hold_full_ff & sent_any_ff;    // R8
    tx_set[SRX_BIT_OVER]  = TX.data_wr & hold_full_ff & ~load_now;          // R10
    tx_set[SRX_BIT_DONE]  = TX.byte_end & ~hold_full_ff & ~TX.data_wr
                          & sent_any_ff;                                    // R12
    tx_set[SRX_BIT_EMPTY] = load_now;                                       // R14
    // Reading status clears underflow, overflow and done; a new byte write clears empty
    tx_clr                = {SRX_EN_W{TX.stat_rd}};
    tx_clr[SRX_BIT_EMPTY] = TX.data_wr;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hold_full_ff <= 1'b0;
      sent_any_ff  <= 1'b0;
    end else begin
      hold_full_ff <= nxt_hold_full;
      sent_any_ff  <= nxt_sent_any;
    end
  end

  // ************************************************
  // Sticky transmit status, one slice per bit
  // ************************************************
  logic [SRX_EN_W-1:0] tx_stat_ff;
  logic [SRX_EN_W-1:0] nxt_tx_stat;

  // Set wins over clear so an event in the clearing cycle is kept
  generate
    for (genvar i = 0; i < SRX_EN_W; i++) begin : g_stat
      always_comb begin
        nxt_tx_stat[i] = tx_set[i] | (tx_stat_ff[i] & ~tx_clr[i]);  // R15
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_stat_ff <= SRX_RST_EN;
    end else begin
      tx_stat_ff <= nxt_tx_stat;
    end
  end

  assign TX_STATUS    = tx_stat_ff;
  assign TX_HOLD_FULL = hold_full_ff;

  // ************************************************
  // Interrupt enable register and request
  // ************************************************
  logic [SRX_EN_W-1:0] tx_en_ff;
  logic [SRX_EN_W-1:0] nxt_tx_en;
  logic                irq_ff;
  logic                nxt_irq;
  logic                irq_raw;

  // Only the low nibble is stored; upper bits are reserved
  always_comb begin
    nxt_tx_en = tx_en_ff;
    if (REG_REQ.wr && (REG_REQ.addr == SRX_ADDR_TX_IRQ_EN)) begin
      nxt_tx_en = REG_REQ.wdata[SRX_EN_W-1:0];  // R6
    end
  end

  // Each enable bit gates its own status bit onto the request
  assign irq_raw = |(tx_stat_ff & tx_en_ff);  // R7 R9 R11 R13
  assign nxt_irq = irq_raw;                   // R17

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_en_ff <= SRX_RST_EN;
      irq_ff   <= 1'b0;
    end else begin
      tx_en_ff <= nxt_tx_en;
      irq_ff   <= nxt_irq;
    end
  end

  assign TX_IRQ = irq_ff;

  // ************************************************
  // Register read port
  // ************************************************
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Data lands one edge after the read strobe; unmapped offsets read zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        SRX_ADDR_RXA_VALID: nxt_rdata = rxa_mask_ff;          // R1
        SRX_ADDR_RXB_DATA:  nxt_rdata = rxb_data_ff;          // R3
        SRX_ADDR_RXB_VALID: nxt_rdata = rxb_mask_ff;          // R4
        SRX_ADDR_TX_IRQ_EN: nxt_rdata = {4'h0, tx_en_ff};
        default:            nxt_rdata = SRX_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_ff <= SRX_RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  // Receive capture and read-back; a load in the read cycle is left out on purpose
  rxa_mask_cap_a: assert property ( // R1
      RXA.load |=> rxa_mask_ff == $past(RXA.valid))
    else $error("channel A mask not captured");
  rxa_mask_rd_a: assert property ( // R1
      REG_REQ.rd && REG_REQ.addr == SRX_ADDR_RXA_VALID && !RXA.load |=> REG_RDATA == rxa_mask_ff)
    else $error("channel A mask read wrong");
  rxa_flag_a: assert property ( // R2
      RXA_ALL_VALID |-> rxa_mask_ff == SRX_ALL_VALID)
    else $error("channel A flag set with partial mask");
  rxb_data_cap_a: assert property ( // R3
      RXB.load |=> rxb_data_ff == $past(RXB.data))
    else $error("channel B data not captured");
  rxb_data_rd_a: assert property ( // R3
      REG_REQ.rd && REG_REQ.addr == SRX_ADDR_RXB_DATA && !RXB.load |=> REG_RDATA == rxb_data_ff)
    else $error("channel B data read wrong");
  rxb_mask_rd_a: assert property ( // R4
      REG_REQ.rd && REG_REQ.addr == SRX_ADDR_RXB_VALID && !RXB.load |=> REG_RDATA == rxb_mask_ff)
    else $error("channel B mask read wrong");
  rxb_flag_a: assert property ( // R5
      RXB_ALL_VALID |-> rxb_mask_ff == SRX_ALL_VALID)
    else $error("channel B flag set with partial mask");
  all_valid_set_a: assert property ( // R16
      RXB.load |=> RXB_ALL_VALID == (&$past(RXB.valid)))
    else $error("channel B flag not tied to mask");
  rxa_all_set_a: assert property ( // R16
      RXA.load |=> RXA_ALL_VALID == (&$past(RXA.valid)))
    else $error("channel A flag not tied to mask");

  // Enable register: low nibble stored, reserved bits always read back as zero
  en_rsvd_a: assert property ( // R6
      REG_REQ.rd && REG_REQ.addr == SRX_ADDR_TX_IRQ_EN |=> REG_RDATA[7:SRX_EN_W] == '0)
    else $error("reserved enable bits read nonzero");
  en_write_a: assert property ( // R6
      REG_REQ.wr && REG_REQ.addr == SRX_ADDR_TX_IRQ_EN
      |=> tx_en_ff == $past(REG_REQ.wdata[SRX_EN_W-1:0]))
    else $error("enable write not stored");

  // Transmit event detection and sticky status
  under_det_a: assert property ( // R8
      TX.sample_req && !hold_full_ff && sent_any_ff |=> TX_STATUS[SRX_BIT_UNDER])
    else $error("underflow missed");
  no_early_a: assert property ( // R8
      !sent_any_ff |-> !TX_STATUS[SRX_BIT_UNDER] && !TX_STATUS[SRX_BIT_DONE])
    else $error("underflow or done before first load");
  over_det_a: assert property ( // R10
      TX.data_wr && hold_full_ff && !TX.sample_req |=> TX_STATUS[SRX_BIT_OVER] && TX_HOLD_FULL)
    else $error("overflow missed");
  hold_track_a: assert property ( // R10
      TX.data_wr |=> TX_HOLD_FULL)
    else $error("written byte not held");
  done_det_a: assert property ( // R12
      TX.byte_end && !hold_full_ff && !TX.data_wr && sent_any_ff |=> TX_STATUS[SRX_BIT_DONE])
    else $error("done missed");
  stat_keep_a: assert property ( // R12
      TX_STATUS[SRX_BIT_DONE] && !TX.stat_rd |=> TX_STATUS[SRX_BIT_DONE])
    else $error("done dropped without status read");
  empty_det_a: assert property ( // R14
      TX.sample_req && hold_full_ff
      |=> TX_STATUS[SRX_BIT_EMPTY] && (!TX_HOLD_FULL || $past(TX.data_wr)))
    else $error("empty missed");
  poll_no_en_a: assert property ( // R15
      TX.data_wr && hold_full_ff && !TX.sample_req && !tx_en_ff[SRX_BIT_OVER]
      |=> TX_STATUS[SRX_BIT_OVER])
    else $error("status gated by enable");

  // Interrupt gating, one cycle behind status and enable
  under_gate_a: assert property ( // R7
      tx_en_ff[SRX_BIT_UNDER] && TX_STATUS[SRX_BIT_UNDER] |=> TX_IRQ)
    else $error("underflow enable ignored");
  over_gate_a: assert property ( // R9
      tx_en_ff[SRX_BIT_OVER] && TX_STATUS[SRX_BIT_OVER] |=> TX_IRQ)
    else $error("overflow enable ignored");
  done_gate_a: assert property ( // R11
      tx_en_ff[SRX_BIT_DONE] && TX_STATUS[SRX_BIT_DONE] |=> TX_IRQ)
    else $error("done enable ignored");
  empty_on_a: assert property ( // R13
      tx_en_ff[SRX_BIT_EMPTY] && TX_STATUS[SRX_BIT_EMPTY] |=> TX_IRQ)
    else $error("empty enable ignored");
  empty_gate_a: assert property ( // R13
      !tx_en_ff[SRX_BIT_EMPTY] && TX_STATUS[SRX_BIT_EMPTY]
      && TX_STATUS[SRX_BIT_UNDER:SRX_BIT_DONE] == '0 |=> !TX_IRQ)
    else $error("empty enable leaks");
  irq_req_a: assert property ( // R17
      1'b1 |=> TX_IRQ == (|($past(TX_STATUS) & $past(tx_en_ff))))
    else $error("interrupt request mismatch");

  cov_rx_full_c: cover property (RXB.load && RXB.valid == SRX_ALL_VALID ##1 RXB_ALL_VALID);
  cov_over_c:    cover property (TX.data_wr ##2 TX.data_wr ##1 TX_STATUS[SRX_BIT_OVER]);
  cov_under_c:   cover property (TX_STATUS[SRX_BIT_EMPTY] ##[1:20] TX_STATUS[SRX_BIT_UNDER]);
  cov_irq_c:     cover property ($rose(TX_IRQ));
  cov_win_c:     cover property (TX.byte_end && TX.stat_rd && sent_any_ff && !hold_full_ff
                                 ##1 TX_STATUS[SRX_BIT_DONE]);

endmodule

// ==== test/srx_host.sv ====
// Host model that reaches the register bank through decoded strobes
`timescale 1ns/10ps
module srx_host
  import srx_pkg::*;
(
  input  wire logic       CORE_CLK,
  output srx_reg_req_t    REG_REQ,
  input  wire logic [7:0] REG_RDATA
);
  // ************************************************
  // Bus cycles
  // ************************************************
  // Idle lines start at zero; after each strobe they carry the inverted address and all-ones data so nothing stale looks valid
  initial REG_REQ = '0;

  // One write strobe; upper enable bits always go out as zeroes
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] e);
    @(posedge CORE_CLK) REG_REQ <= '{1'b0, 1'b1, a, {4'h0, e}};
    @(posedge CORE_CLK) REG_REQ <= '{1'b0, 1'b0, ~a, 8'hFF};
  endtask

  // One read strobe; data lands on the taking edge and is sampled just after it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
    @(posedge CORE_CLK) REG_REQ <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge CORE_CLK) REG_REQ <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1 q = REG_RDATA;
  endtask
endmodule

// ==== test/serdes_rx_valid_tx_irq_enable_bench.sv ====
// Self-checking bench for the rx valid mask and tx interrupt enable bank
`timescale 1ns/10ps
module serdes_rx_valid_tx_irq_enable_bench;
  import srx_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst_b    = 1'b0;
  srx_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  srx_rx_t      rxa      = '0;
  srx_rx_t      rxb      = '0;
  logic         rxa_all;
  logic         rxb_all;
  srx_tx_ev_t   tx       = '0;
  logic [3:0]   tx_status;
  logic         hold_full;
  logic         tx_irq;
  int           bad_count = 0;
  int           n_checks  = 0;
  logic [7:0]   q;

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  srx_regs dut (.CORE_CLK(core_clk), .RST_B(rst_b), .REG_REQ(reg_req),
    .REG_RDATA(reg_rdata), .RXA(rxa), .RXB(rxb), .RXA_ALL_VALID(rxa_all),
    .RXB_ALL_VALID(rxb_all), .TX(tx), .TX_STATUS(tx_status),
    .TX_HOLD_FULL(hold_full), .TX_IRQ(tx_irq));

  srx_host host (.CORE_CLK(core_clk), .REG_REQ(reg_req), .REG_RDATA(reg_rdata));

  // ************************************************
  // Helpers
  // ************************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    host.rd_reg(a, q);
    chk(n, e, q);
  endtask

  // One-cycle receive load; outputs are settled one edge later
  task automatic rx_load(input bit b, input logic [7:0] d, input logic [7:0] v);
    @(posedge core_clk) begin
      if (b) rxb <= '{1'b1, d, v};
      else rxa <= '{1'b1, d, v};
    end
    @(posedge core_clk) begin
      rxa.load <= 1'b0;
      rxb.load <= 1'b0;
    end
    #1;
  endtask

  // One-cycle transmit event, status compared after it has landed
  task automatic tx_ev(input logic [3:0] e, input logic [3:0] st, input logic h);
    @(posedge core_clk) tx <= srx_tx_ev_t'(e);
    @(posedge core_clk) tx <= '0;
    #1;
    chk("tx_status", {4'h0, st}, {4'h0, tx_status});
    chk("hold_full", {7'h00, h}, {7'h00, hold_full});
  endtask

  // Verdict in one place, reached by the tests or the watchdog
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog, well past the fewer than a hundred cycles the tests need
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end

  // ************************************************
  // Tests
  // ************************************************
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset values, and an unmapped offset reads zero
    for (int a = 8'h0A; a <= 8'h0E; a++) begin
      rd_chk("reset", 8'(a), 8'h00);
    end
    $display("test reset done");
    // Channel B byte order and mask, then a partial mask, then channel A partial and full masks
    rx_load(1'b1, 8'h5A, 8'hFF);
    chk("rxb_all", 8'h01, {7'h00, rxb_all});
    rd_chk("rxb_data", SRX_ADDR_RXB_DATA, 8'h5A);
    rd_chk("rxb_mask", SRX_ADDR_RXB_VALID, 8'hFF);
    rx_load(1'b1, 8'h81, 8'h7F);
    chk("rxb_all", 8'h00, {7'h00, rxb_all});
    rd_chk("rxb_mask", SRX_ADDR_RXB_VALID, 8'h7F);
    rx_load(1'b0, 8'h3C, 8'hC3);
    chk("rxa_all", 8'h00, {7'h00, rxa_all});
    rd_chk("rxa_mask", SRX_ADDR_RXA_VALID, 8'hC3);
    rx_load(1'b0, 8'h00, 8'hFF);
    chk("rxa_all", 8'h01, {7'h00, rxa_all});
    $display("test receive done");
    // No underflow or done before the first byte reaches the shifter
    tx_ev(4'h4, 4'h0, 1'b0);
    tx_ev(4'h2, 4'h0, 1'b0);
    tx_ev(4'h8, 4'h0, 1'b1);
    tx_ev(4'h8, 4'h4, 1'b1);
    tx_ev(4'h4, 4'h5, 1'b0);
    tx_ev(4'h2, 4'h7, 1'b0);
    tx_ev(4'h4, 4'hF, 1'b0);
    chk("irq_off", 8'h00, {7'h00, tx_irq});
    $display("test transmit done");
    // Each enable bit alone raises the request from its pending status
    for (int i = 0; i < 4; i++) begin
      host.wr_reg(SRX_ADDR_TX_IRQ_EN, 4'(1 << i));
      rd_chk("irq_en", SRX_ADDR_TX_IRQ_EN, 8'(1 << i));
      chk("irq_on", 8'h01, {7'h00, tx_irq});
    end
    // Status read leaves only empty; enabled underflow then drops the request
    tx_ev(4'h1, 4'h1, 1'b0);
    @(posedge core_clk) #1;
    chk("irq_clr", 8'h00, {7'h00, tx_irq});
    tx_ev(4'h8, 4'h0, 1'b1);
    // Write and load in one cycle: no overflow, and empty set beats the write's clear
    tx_ev(4'hC, 4'h1, 1'b1);
    tx_ev(4'h4, 4'h1, 1'b0);
    // Events landing with a status read are kept, the read clears the other event bits but not empty
    tx_ev(4'h3, 4'h3, 1'b0);
    tx_ev(4'h5, 4'h9, 1'b0);
    @(posedge core_clk) #1;
    chk("irq_under", 8'h01, {7'h00, tx_irq});
    $display("test interrupt done");
    end_of_test();
  end
endmodule
